/* verilog/halt_defs.svh */
// constants for the halt mode controller
`ifndef HALT_DEFS_SVH
`define HALT_DEFS_SVH

`define HALT_OPCODE 8'h8e
`define STAB_CYC_SHORT 10'd256
`define STAB_CYC_LONG 10'd512
`define STAB_CNT_W 10
`define EXT_IRQ_W 5
`define IRQ_MASK_RESET 1'b1

`endif

/* verilog/halt_pkg.sv */
// types shared by the halt mode controller
`default_nettype none
package halt_pkg;
`include "halt_defs.svh"

  typedef enum logic [2:0] {
    ST_BOOT,
    ST_RUN,
    ST_ACT_HALT,
    ST_FULL_HALT,
    ST_STAB
  } pwr_state_t;

  typedef struct packed {
    logic timebase_irq_enable;
    logic overflow_irq_enable;
    logic timer_clk_sel_hi;
    logic timer_clk_sel_lo;
  } timer_cfg_t;

  typedef struct packed {
    logic rtc;
    logic autoreload;
    logic [`EXT_IRQ_W-1:0] ext;
    logic other;
  } irq_req_t;

endpackage : halt_pkg
`default_nettype wire

/* verilog/stab_counter.sv */
// oscillator stabilisation down-counter
`timescale 1ns/1ns
`default_nettype none
`include "halt_defs.svh"
module stab_counter #(
  parameter logic [`STAB_CNT_W-1:0] SHORT_CYC = `STAB_CYC_SHORT,
  parameter logic [`STAB_CNT_W-1:0] LONG_CYC = `STAB_CYC_LONG
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_sel_long,
  output logic o_busy,
  output logic o_done
);
  logic [`STAB_CNT_W-1:0] cnt;
  logic [`STAB_CNT_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (i_start) begin
      next_cnt = i_sel_long ? LONG_CYC : SHORT_CYC;
    end else if (cnt != '0) begin
      next_cnt = cnt - `STAB_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign o_busy = (cnt != '0);
  // last counted cycle
  assign o_done = (cnt == `STAB_CNT_W'(1));
endmodule : stab_counter
`default_nettype wire

/* verilog/halt_mode_controller.sv */
// halt and active-halt mode controller
`timescale 1ns/1ns
`default_nettype none
`include "halt_defs.svh"
// What this block does
// RULE1: halt instruction enters active-halt or full halt from timer settings.
// RULE2: active-halt if timebase enable, or overflow enable with select 0,1.
// RULE3: active-halt keeps oscillator and selected timer clocked, rest gated.
// RULE4: active-halt exits only on lite timer, autoreload timer irq or reset.
// RULE5: reset exit waits 256 or 512 cycles before reset vector fetch.
// RULE6: timer irq exit from active-halt services vector with no delay.
// RULE7: halt entry clears the interrupt mask bit; pending request wakes at once.
// RULE8: full halt stops main oscillator and all peripherals.
// RULE9: full halt exit restarts oscillator, waits 256 or 512 cycles first.
// RULE10: only external halt-capable interrupts wake from full halt.
// RULE11: watchdog-halt option may turn halt into a watchdog reset.
// RULE12: active-halt with option cleared never gives a watchdog reset.
// RULE13: servicing wakeup pushes condition codes and sets mask; pop clears it.
// RULE14: software switches cpu clock to slow source before halt.
// RULE15: halt decoded from opcode 8e.
// RULE16: software should clear pending interrupt flags before halt.
// RULE17: software reconfigures wakeup pins and sensitivity before halt.
// RULE18: 256 or 512 delay chosen by a static configuration input.
module halt_mode_controller
  import halt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_instr_valid,
  input wire logic [7:0] i_opcode,
  input wire timer_cfg_t i_timer_cfg,
  input wire irq_req_t i_irq,
  input wire logic i_delay_512,
  input wire logic i_watchdog_enabled,
  input wire logic i_watchdog_halt_option,
  input wire logic i_mask_set,
  input wire logic i_mask_clear,
  input wire logic i_ccr_pop,
  output logic o_cpu_clk_en,
  output logic o_osc_en,
  output logic o_periph_clk_en,
  output logic o_lite_timer_clk_en,
  output logic o_autoreload_timer_clk_en,
  output logic o_irq_mask,
  output logic o_ccr_push,
  output logic o_service_irq,
  output logic o_fetch_reset_vector,
  output logic o_watchdog_reset,
  output pwr_state_t o_state
);
  // ----------------------------------------
  // mode decision
  // ----------------------------------------
  pwr_state_t state, next_state;
  logic wake_by_irq, next_wake_by_irq;
  logic irq_mask, next_irq_mask;
  logic next_ccr_push, next_service, next_fetch, next_wdg_reset;
  logic halt_cmd, act_halt_en, wdg_trip, ah_wake, fh_wake;
  logic stab_start, stab_busy, stab_done;

  // RULE15 opcode decode
  assign halt_cmd = i_instr_valid && (i_opcode == `HALT_OPCODE) && (state == ST_RUN);
  // RULE2 enable combinations
  assign act_halt_en = i_timer_cfg.timebase_irq_enable |
                       (i_timer_cfg.overflow_irq_enable & ~i_timer_cfg.timer_clk_sel_hi &
                        i_timer_cfg.timer_clk_sel_lo);
  // RULE11 RULE12 watchdog halt option
  assign wdg_trip = i_watchdog_enabled & ~i_watchdog_halt_option & ~act_halt_en;
  // RULE4 active-halt wake sources
  assign ah_wake = i_irq.rtc | i_irq.autoreload;
  // RULE10 full halt wake sources
  assign fh_wake = |i_irq.ext;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_wake_by_irq = wake_by_irq;
    next_irq_mask = irq_mask;
    next_ccr_push = 1'b0;
    next_service = 1'b0;
    next_fetch = 1'b0;
    next_wdg_reset = 1'b0;
    stab_start = 1'b0;
    // RULE13 pop restores open mask
    if (i_ccr_pop || (state == ST_RUN && i_mask_clear)) begin
      next_irq_mask = 1'b0;
    end
    if (state == ST_RUN && i_mask_set) begin
      next_irq_mask = 1'b1;
    end
    case (state)
      ST_BOOT: begin
        // RULE5 RULE18 delay after reset
        next_state = ST_STAB;
        next_wake_by_irq = 1'b0;
        stab_start = 1'b1;
      end
      ST_RUN: begin
        if (halt_cmd) begin
          if (wdg_trip) begin
            // RULE11 watchdog reset instead
            next_wdg_reset = 1'b1;
          end else begin
            // RULE1 RULE7 RULE8 mode entry
            next_state = act_halt_en ? ST_ACT_HALT : ST_FULL_HALT;
            next_irq_mask = 1'b0;
          end
        end
      end
      ST_ACT_HALT: begin
        if (ah_wake) begin
          // RULE6 RULE13 immediate service
          next_state = ST_RUN;
          next_service = 1'b1;
          next_ccr_push = 1'b1;
          next_irq_mask = 1'b1;
        end
      end
      ST_FULL_HALT: begin
        if (fh_wake) begin
          // RULE9 restart and stabilise
          next_state = ST_STAB;
          next_wake_by_irq = 1'b1;
          stab_start = 1'b1;
        end
      end
      ST_STAB: begin
        if (stab_done) begin
          next_state = ST_RUN;
          if (wake_by_irq) begin
            // RULE13 service after delay
            next_service = 1'b1;
            next_ccr_push = 1'b1;
            next_irq_mask = 1'b1;
          end else begin
            next_fetch = 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_BOOT;
      wake_by_irq <= 1'b0;
      irq_mask <= `IRQ_MASK_RESET;
      o_ccr_push <= 1'b0;
      o_service_irq <= 1'b0;
      o_fetch_reset_vector <= 1'b0;
      o_watchdog_reset <= 1'b0;
    end else begin
      state <= next_state;
      wake_by_irq <= next_wake_by_irq;
      irq_mask <= next_irq_mask;
      o_ccr_push <= next_ccr_push;
      o_service_irq <= next_service;
      o_fetch_reset_vector <= next_fetch;
      o_watchdog_reset <= next_wdg_reset;
    end
  end

  // RULE18 static delay select
  stab_counter u_stab (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_start(stab_start),
    .i_sel_long(i_delay_512),
    .o_busy(stab_busy),
    .o_done(stab_done)
  );

  // ----------------------------------------
  // clock gating
  // ----------------------------------------
  // RULE3 RULE8 gating per mode
  assign o_osc_en = (state != ST_FULL_HALT);
  assign o_cpu_clk_en = (state == ST_RUN);
  assign o_periph_clk_en = (state == ST_RUN);
  assign o_lite_timer_clk_en = (state == ST_RUN) ||
                               (state == ST_ACT_HALT && i_timer_cfg.timebase_irq_enable);
  assign o_autoreload_timer_clk_en = (state == ST_RUN) ||
                                     (state == ST_ACT_HALT && !i_timer_cfg.timebase_irq_enable);
  assign o_irq_mask = irq_mask;
  assign o_state = state;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_enter_active;
    halt_cmd && act_halt_en |=> state == ST_ACT_HALT && !o_irq_mask;
  endproperty
  a_enter_active: assert property (p_enter_active) else $error("active-halt not entered"); // RULE2

  property p_enter_full;
    halt_cmd && !act_halt_en && !wdg_trip |=> !o_osc_en && !o_periph_clk_en && !o_irq_mask;
  endproperty
  a_enter_full: assert property (p_enter_full) else $error("full halt not entered"); // RULE8

  property p_active_clocks;
    state == ST_ACT_HALT |-> o_osc_en && !o_cpu_clk_en && !o_periph_clk_en &&
      (o_lite_timer_clk_en == i_timer_cfg.timebase_irq_enable) &&
      (o_lite_timer_clk_en != o_autoreload_timer_clk_en);
  endproperty
  a_active_clocks: assert property (p_active_clocks) else $error("active-halt gating wrong"); // RULE3

  property p_active_hold;
    state == ST_ACT_HALT && !i_irq.rtc && !i_irq.autoreload |=> state == ST_ACT_HALT;
  endproperty
  a_active_hold: assert property (p_active_hold) else $error("active-halt left wrongly"); // RULE4

  property p_active_wake;
    state == ST_ACT_HALT && (i_irq.rtc || i_irq.autoreload) |=>
      o_service_irq && o_ccr_push && o_irq_mask && state == ST_RUN;
  endproperty
  a_active_wake: assert property (p_active_wake) else $error("timer wake not immediate"); // RULE6

  property p_full_hold;
    state == ST_FULL_HALT && i_irq.ext == '0 |=> state == ST_FULL_HALT;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full halt left wrongly"); // RULE10

  property p_full_stab;
    state == ST_FULL_HALT && i_irq.ext != '0 && !i_delay_512 |=>
      (o_osc_en && !o_service_irq) [*8] ##248 !o_service_irq ##1 o_service_irq;
  endproperty
  a_full_stab: assert property (p_full_stab) else $error("stabilisation delay wrong"); // RULE9

  property p_wdg;
    halt_cmd && wdg_trip |=> o_watchdog_reset && state == ST_RUN;
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog reset missing"); // RULE11

  property p_wdg_active;
    halt_cmd && act_halt_en |=> !o_watchdog_reset;
  endproperty
  a_wdg_active: assert property (p_wdg_active) else $error("reset in active-halt"); // RULE12

  property p_decode;
    state == ST_RUN && i_instr_valid && i_opcode != `HALT_OPCODE |=> state == ST_RUN;
  endproperty
  a_decode: assert property (p_decode) else $error("halt from wrong opcode"); // RULE15

  property p_reset_fetch;
    o_fetch_reset_vector |-> $past(state) == ST_STAB && !wake_by_irq;
  endproperty
  a_reset_fetch: assert property (p_reset_fetch) else $error("bad reset fetch"); // RULE5

  property p_stab_hold;
    state == ST_STAB |-> stab_busy && o_osc_en && !o_cpu_clk_en && !o_periph_clk_en;
  endproperty
  a_stab_hold: assert property (p_stab_hold) else $error("cpu clocked during start-up"); // RULE9

  c_active_cycle: cover property (state == ST_ACT_HALT ##[1:20] o_service_irq);
  c_full_cycle: cover property (state == ST_FULL_HALT ##1 state == ST_STAB);
  c_wdg_trip: cover property (o_watchdog_reset);
endmodule : halt_mode_controller
`default_nettype wire

/* tb/irq_source.sv */
// pending interrupt flags seen by the controller
`timescale 1ns/1ns
`default_nettype none
module irq_source
  import halt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire irq_req_t i_set,
  input wire logic i_ack,
  output irq_req_t o_irq
);
  // ----------------------------------------
  // flags held until the routine runs
  // ----------------------------------------
  // all flags cleared together by the service pulse on i_ack
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_irq <= '0;
    end else begin
      o_irq <= (o_irq | i_set) & ~{8{i_ack}};
    end
  end
endmodule : irq_source
`default_nettype wire

/* tb/halt_mode_controller_bench.sv */
// self-checking bench for the halt mode controller
`timescale 1ns/1ns
`default_nettype none
`include "halt_defs.svh"
module halt_mode_controller_bench
  import halt_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic vld = 1'b0;
  logic d512 = 1'b0;
  logic wde = 1'b0;
  logic wdo = 1'b0;
  logic mset = 1'b0;
  logic mclr = 1'b0;
  logic pop = 1'b0;
  logic [7:0] opc = 8'h00;
  timer_cfg_t cfg = '0;
  irq_req_t set_irq = '0;
  irq_req_t irq;
  logic cpu_en, osc_en, per_en, lt_en, at_en, mask, push, svc, fetch, wdr;
  pwr_state_t st;
  int miscompares = 0;
  int tests_run = 0;
  int n;
  always #4 clk = ~clk;
  // ----------------------------------------
  // design and interrupt sources
  // ----------------------------------------
  halt_mode_controller i_dut (.i_clk(clk), .i_nrst(nrst), .i_instr_valid(vld),
    .i_opcode(opc), .i_timer_cfg(cfg), .i_irq(irq), .i_delay_512(d512),
    .i_watchdog_enabled(wde), .i_watchdog_halt_option(wdo), .i_mask_set(mset),
    .i_mask_clear(mclr), .i_ccr_pop(pop), .o_cpu_clk_en(cpu_en), .o_osc_en(osc_en),
    .o_periph_clk_en(per_en), .o_lite_timer_clk_en(lt_en),
    .o_autoreload_timer_clk_en(at_en), .o_irq_mask(mask), .o_ccr_push(push),
    .o_service_irq(svc), .o_fetch_reset_vector(fetch), .o_watchdog_reset(wdr),
    .o_state(st));
  irq_source i_src (.i_clk(clk), .i_nrst(nrst), .i_set(set_irq), .i_ack(svc), .o_irq(irq));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic halt(input logic [7:0] op);
    // drives op with valid high for one clock
    @(negedge clk);
    opc = op;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
  endtask : halt
  task automatic raise(input irq_req_t r);
    @(negedge clk);
    set_irq = r;
    @(negedge clk);
    set_irq = '0;
  endtask : raise
  // edges until a service or reset-vector pulse shows
  task automatic wait_pulse(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (svc !== 1'b1 && fetch !== 1'b1 && k < 2000);
  endtask : wait_pulse
  task automatic do_reset(input logic l);
    @(negedge clk);
    nrst = 1'b0;
    d512 = l;
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    wait_pulse(n);
    chk(n[15:0], (l ? `STAB_CYC_LONG : `STAB_CYC_SHORT) + 16'h0001);
    chk({fetch, mask, st}, {2'b11, ST_RUN});
  endtask : do_reset
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    logic act;
    do_reset(1'b0);
    cfg = 4'b1000;
    halt(8'h8f);
    chk(st, ST_RUN);
    halt(`HALT_OPCODE);
    chk({st, mask}, {ST_ACT_HALT, 1'b0});
    chk({cpu_en, per_en, osc_en, lt_en, at_en}, 16'h0006);
    raise(8'h3f);
    @(negedge clk);
    chk(st, ST_ACT_HALT);
    raise(8'h80);
    wait_pulse(n);
    chk({n[7:0], svc, push, mask}, {8'h01, 3'b111});
    @(negedge clk);
    pop = 1'b1;
    @(negedge clk);
    pop = 1'b0;
    chk(mask, 1'b0);
    for (int i = 0; i < 16; i++) begin
      cfg = timer_cfg_t'(i[3:0]);
      act = cfg.timebase_irq_enable |
            (cfg.overflow_irq_enable & !cfg.timer_clk_sel_hi & cfg.timer_clk_sel_lo);
      halt(`HALT_OPCODE);
      chk(st, act ? ST_ACT_HALT : ST_FULL_HALT);
      chk({osc_en, at_en}, act ? {1'b1, !cfg.timebase_irq_enable} : 2'b00);
      if (!act) begin
        raise(8'h81);
        @(negedge clk);
        chk(st, ST_FULL_HALT);
      end
      raise(act ? (cfg.timebase_irq_enable ? 8'h80 : 8'h40) : 8'h02);
      wait_pulse(n);
      chk(n[15:0], act ? 16'h0001 : `STAB_CYC_SHORT + 16'h0001);
    end
    @(negedge clk);
    mclr = 1'b1;
    @(negedge clk);
    mclr = 1'b0;
    chk(mask, 1'b0);
    mset = 1'b1;
    @(negedge clk);
    mset = 1'b0;
    chk(mask, 1'b1);
    wde = 1'b1;
    cfg = 4'b0000;
    halt(`HALT_OPCODE);
    chk({wdr, st}, {1'b1, ST_RUN});
    cfg = 4'b0101;
    halt(`HALT_OPCODE);
    chk({wdr, st}, {1'b0, ST_ACT_HALT});
    raise(8'h40);
    wait_pulse(n);
    chk(n[15:0], 16'h0001);
    wdo = 1'b1;
    cfg = 4'b0000;
    halt(`HALT_OPCODE);
    chk({wdr, st}, {1'b0, ST_FULL_HALT});
    do_reset(1'b1);
    final_report();
  end
  initial begin
    #400000;
    miscompares++;
    final_report();
  end
endmodule : halt_mode_controller_bench
`default_nettype wire
